// ### shared/efr_map.svh
// register map, field positions, reset values and frame offsets
// of the egress frame rewriter; definitions only, no logic.
`ifndef EFR_MAP_SVH
`define EFR_MAP_SVH

// ============================================================
// register offsets (byte addresses on the 32-bit bus)
`define EFR_CFG_OFS 12'h000
`define EFR_DLY_OFS 12'h004
`define EFR_STAT_OFS 12'h008
`define EFR_GREEN_PAGE 4'h1
`define EFR_YELLOW_PAGE 4'h2

// ============================================================
// remark_port_config fields and reset values
`define EFR_CFG_MODE_LSB 0
`define EFR_CFG_FCS_LSB 2
`define EFR_CFG_CPU_EN 4
`define EFR_CFG_BP 5
`define EFR_CFG_DIS1 6
`define EFR_CFG_DIS2 7
`define EFR_CFG_RST 8'h00
`define EFR_DLY_RST 32'h0000_0000
`define EFR_STAT_BUSY 16

// ============================================================
// frame layout
`define EFR_ETYPE_OFS 11'h00c
`define EFR_TPID_C 16'h8100
`define EFR_TPID_S 16'h88a8
`define EFR_ET_PTP 16'h88f7
`define EFR_ET_IPV4 16'h0800
`define EFR_ET_IPV6 16'h86dd
`define EFR_PROTO_UDP 8'h11
`define EFR_V4_PROTO 11'h009
`define EFR_V4_CSUM 11'h00a
`define EFR_V6_NH 11'h006
`define EFR_V4_PTP 11'h01c
`define EFR_V6_PTP 11'h030
`define EFR_PTP_CF 11'h008
`define EFR_PTP_RSV 11'h010
`define EFR_PTP_TOD 11'h022
`define EFR_TOD_LEN 11'h00a
`define EFR_CRC_POLY 32'hedb8_8320
`define EFR_CRC_INIT 32'hffff_ffff

`endif

// ### shared/efr_pkg.sv
// types shared by the egress frame rewriter and its bench.
// assumes efr_map.svh carries every number.
`default_nettype none
package efr_pkg;

    typedef enum logic [1:0] {
        rm_keep, rm_direct, rm_green, rm_color
    } remark_mode_e;

    typedef enum logic [1:0] {
        fm_never, fm_cond, fm_always, fm_rsvd
    } fcs_mode_e;

    typedef enum logic [2:0] {
        op_none, op_one, op_two, op_origin
    } op_e;

endpackage
`default_nettype wire

// ### hw/egress_frame_rewriter.sv
// egress frame rewriter: dscp remark, ipv4 checksum, ptp stamp edits
// and fcs regeneration on a byte stream, with a wishbone slave.
// assumes analyzer sideband is valid with the first byte of a frame.
//
// Contract
// [RULE1] overwrite dscp of ipv4 and ipv6 frames
// [RULE2] new dscp comes from classified dscp
// [RULE3] four modes: keep, direct, green table
// [RULE4] colour mode picks table by drop level
// [RULE5] ipv4 header checksum fixed, ipv6 none
// [RULE6] no remark when ptp stamping applies
// [RULE7] normal frames: fcs never, always, conditional
// [RULE8] injected frames: fcs never or always
// [RULE9] residence time added to correction field
// [RULE10] add tx time or subtract rx time
// [RULE11] 80-bit time-of-day into origin stamp
// [RULE12] rx stamp written into reserved bytes
// [RULE13] zero written into reserved bytes
// [RULE14] ptp found over ethernet, ipv4, ipv6, vlan
// [RULE15] analyzer gives op code and flags
// [RULE16] analyzer gives rx stamp and ingress backplane
// [RULE17] no backplane: residence plus optional delay
// [RULE18] egress backplane, no addsub: set reserved
// [RULE19] egress backplane with addsub: subtract rx
// [RULE20] ingress backplane: clear reserved, add time
// [RULE21] both backplanes on: leave ptp untouched
// [RULE22] conditional fcs covers all final edits
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "efr_map.svh"

module egress_frame_rewriter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    input wire logic in_sof,
    input wire logic in_eof,
    input wire logic [5:0] cls_dscp,
    input wire logic drop_level,
    input wire logic [2:0] rewriter_operation_code,
    input wire logic addsub_flag,
    input wire logic egress_delay_flag,
    input wire logic [47:0] receive_time_stamp,
    input wire logic ingress_backplane,
    input wire logic cpu_injected,
    input wire logic tag_pushed,
    input wire logic [47:0] tod_seconds,
    input wire logic [47:0] tx_time_ns,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data,
    output logic out_sof,
    output logic out_eof
);

    // ========================================================
    // register file
    logic ack_q;
    logic [31:0] dat_q;
    logic [7:0] cfg_q;
    logic [31:0] dly_q;
    logic [5:0] tbl_g [64];
    logic [5:0] tbl_y [64];
    logic [15:0] frames_q;
    logic eof_seen_q;

    wire acc = wb_cyc_i && wb_stb_i && !ack_q;
    wire wr = acc && wb_we_i;
    wire [5:0] tix = wb_adr_i[7:2];
    wire sel_cfg = wb_adr_i == `EFR_CFG_OFS;
    wire sel_dly = wb_adr_i == `EFR_DLY_OFS;
    wire sel_st = wb_adr_i == `EFR_STAT_OFS;
    wire sel_g = wb_adr_i[11:8] == `EFR_GREEN_PAGE;
    wire sel_y = wb_adr_i[11:8] == `EFR_YELLOW_PAGE;
    wire [31:0] rd_st = {15'h0, eof_seen_q, frames_q};
    wire [31:0] rd =
        sel_cfg ? {24'h0, cfg_q} :
        sel_dly ? dly_q :
        sel_st ? rd_st :
        sel_g ? {26'h0, tbl_g[tix]} :
        sel_y ? {26'h0, tbl_y[tix]} : 32'h0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= acc;
            dat_q <= acc ? rd : 32'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_q <= `EFR_CFG_RST;
            dly_q <= `EFR_DLY_RST;
            for (int i = 0; i < 64; i++) begin
                tbl_g[i] <= 6'h0;
                tbl_y[i] <= 6'h0;
            end
        end else if (wr) begin
            if (sel_cfg && wb_sel_i[0]) begin
                cfg_q <= wb_dat_i[7:0];
            end
            for (int b = 0; b < 4; b++) begin
                if (sel_dly && wb_sel_i[b]) begin
                    dly_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
                end
            end
            if (sel_g && wb_sel_i[0]) begin
                tbl_g[tix] <= wb_dat_i[5:0];
            end
            if (sel_y && wb_sel_i[0]) begin
                tbl_y[tix] <= wb_dat_i[5:0];
            end
        end
    end

    wire [1:0] mode = cfg_q[`EFR_CFG_MODE_LSB +: 2];
    wire [1:0] fmode = cfg_q[`EFR_CFG_FCS_LSB +: 2];
    wire ebp = cfg_q[`EFR_CFG_BP];

    // ========================================================
    // input skid: in_ready is registered, so one byte may land
    // here while the output stalls
    logic in_ready_q;
    logic skid_v_q;
    logic [7:0] skid_d_q;
    logic skid_s_q;
    logic skid_e_q;
    logic drain_q;
    logic out_valid_q;
    logic [7:0] vld_q;
    logic [7:0] sh_q [8];

    wire take = in_valid && in_ready_q;
    wire src_v = skid_v_q || take;
    wire [7:0] src_data = skid_v_q ? skid_d_q : in_data;
    wire src_sof = skid_v_q ? skid_s_q : in_sof;
    wire src_eof = skid_v_q ? skid_e_q : in_eof;
    wire adv = !out_valid_q || out_ready;
    wire go = adv && (drain_q ? |vld_q : src_v);
    wire enter = go && !drain_q;

    // ========================================================
    // per-frame sideband, caught with the first byte
    logic [5:0] dscp_q;
    logic dp_q;
    logic [2:0] op_q;
    logic as_q;
    logic dlyf_q;
    logic [47:0] rx_q;
    logic ibp_q;
    logic cpu_q;
    logic tag_q;
    logic [47:0] tod_q;
    logic [47:0] txns_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dscp_q <= 6'h0;
            dp_q <= 1'b0;
            op_q <= 3'h0;
            as_q <= 1'b0;
            dlyf_q <= 1'b0;
            rx_q <= 48'h0;
            ibp_q <= 1'b0;
            cpu_q <= 1'b0;
            tag_q <= 1'b0;
            tod_q <= 48'h0;
            txns_q <= 48'h0;
        end else if (take && in_sof) begin
            dscp_q <= cls_dscp;
            dp_q <= drop_level;
            op_q <= rewriter_operation_code;
            as_q <= addsub_flag;
            dlyf_q <= egress_delay_flag;
            rx_q <= receive_time_stamp;
            ibp_q <= ingress_backplane;
            cpu_q <= cpu_injected;
            tag_q <= tag_pushed;
            tod_q <= tod_seconds;
            txns_q <= tx_time_ns;
        end
    end

    // ========================================================
    // ptp action decode
    wire one = op_q == efr_pkg::op_one && !cfg_q[`EFR_CFG_DIS1];
    wire two = op_q == efr_pkg::op_two && !cfg_q[`EFR_CFG_DIS2];
    wire org = op_q == efr_pkg::op_origin && !cfg_q[`EFR_CFG_DIS1];
    // [RULE21] both backplanes on
    wire both = ibp_q && ebp;
    // [RULE17] [RULE19] [RULE20] correction cases
    wire cf_do = one && !both && (!ebp || as_q);
    // [RULE18] set reserved bytes
    wire rsv_set = !both && ebp && ((one && !as_q) || two);
    // [RULE20] clear reserved bytes
    wire rsv_clr = !both && ibp_q && (one || two);
    wire rsv_do = rsv_set || rsv_clr;
    wire tod_do = org && !ebp;
    wire ptp_do = cf_do || rsv_do || tod_do;

    // [RULE9] [RULE10] correction delta in ns
    wire [47:0] dly48 = {{16{dly_q[31]}}, dly_q};
    wire [47:0] base =
        ebp ? 48'h0 - rx_q :
        (ibp_q && as_q) ? txns_q : txns_q - rx_q;
    wire [47:0] delta = base + ((dlyf_q && !ebp) ? dly48 : 48'h0);
    // correction field counts ns in units of 2^-16
    wire [63:0] cf_add = {delta, 16'h0};

    // ========================================================
    // header parser on the entry side
    logic [10:0] pos_q;
    logic [10:0] eth_q;
    logic [1:0] ntag_q;
    logic v4_q;
    logic v6_q;
    logic [10:0] ip_q;
    logic ptp_ok_q;
    logic [10:0] ptp_q;
    logic [7:0] vih_q;
    logic [7:0] tos_q;
    logic mod_q;
    logic done;

    wire [15:0] etype = {sh_q[0], src_data};
    wire [10:0] rip = pos_q - ip_q;
    wire [10:0] rp = pos_q - ptp_q;
    wire is_tag = etype == `EFR_TPID_C || etype == `EFR_TPID_S;
    wire at_et = pos_q == eth_q + 11'd1;
    wire is_udp = src_data == `EFR_PROTO_UDP;

    // [RULE14] locate ptp header behind tags and ip
    always_ff @(posedge clk) begin
        if (!rst_n || done) begin
            pos_q <= 11'h0;
            eth_q <= `EFR_ETYPE_OFS;
            ntag_q <= 2'h0;
            v4_q <= 1'b0;
            v6_q <= 1'b0;
            ip_q <= 11'h0;
            ptp_ok_q <= 1'b0;
            ptp_q <= 11'h0;
            vih_q <= 8'h0;
            tos_q <= 8'h0;
        end else if (enter) begin
            pos_q <= pos_q + 11'd1;
            if (at_et && is_tag && ntag_q != 2'd2) begin
                eth_q <= eth_q + 11'd4;
                ntag_q <= ntag_q + 2'd1;
            end else if (at_et && etype == `EFR_ET_PTP) begin
                ptp_ok_q <= 1'b1;
                ptp_q <= pos_q + 11'd1;
            end else if (at_et && etype == `EFR_ET_IPV4) begin
                v4_q <= 1'b1;
                ip_q <= pos_q + 11'd1;
            end else if (at_et && etype == `EFR_ET_IPV6) begin
                v6_q <= 1'b1;
                ip_q <= pos_q + 11'd1;
            end
            // ipv4 options are not skipped: a 20-byte header is assumed
            if (v4_q && rip == `EFR_V4_PROTO && is_udp) begin
                ptp_ok_q <= 1'b1;
                ptp_q <= ip_q + `EFR_V4_PTP;
            end
            if (v6_q && rip == `EFR_V6_NH && is_udp) begin
                ptp_ok_q <= 1'b1;
                ptp_q <= ip_q + `EFR_V6_PTP;
            end
            if (v4_q && rip == 11'd0) begin
                vih_q <= src_data;
            end
            if (v4_q && rip == 11'd1) begin
                tos_q <= src_data;
            end
        end
    end

    // ========================================================
    // dscp remark
    // [RULE6] ptp stamping suppresses remark
    wire dscp_do = mode != efr_pkg::rm_keep && !ptp_do;
    // [RULE2] [RULE3] [RULE4] pick new codepoint
    wire [5:0] new_dscp =
        mode == efr_pkg::rm_direct ? dscp_q :
        (mode == efr_pkg::rm_color && dp_q) ? tbl_y[dscp_q] :
        tbl_g[dscp_q];
    wire tos_hit = enter && dscp_do && v4_q && rip == 11'd1;
    wire tc0_hit = enter && dscp_do && v6_q && rip == 11'd0;
    wire tc1_hit = enter && dscp_do && v6_q && rip == 11'd1;
    wire csum_hit =
        enter && dscp_do && v4_q && rip == `EFR_V4_CSUM + 11'd1;

    function automatic [15:0] oc_add(input [15:0] a, input [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        oc_add = s[15:0] + {15'h0, s[16]};
    endfunction

    // [RULE5] incremental ipv4 header checksum
    wire [15:0] hc = {sh_q[0], src_data};
    wire [15:0] m_old = {vih_q, tos_q};
    wire [15:0] m_new = {vih_q, new_dscp, tos_q[1:0]};
    wire [15:0] hc_n = ~oc_add(oc_add(~hc, ~m_old), m_new);

    // ========================================================
    // ptp field edits
    wire in_ptp = enter && ptp_ok_q;
    wire cf_hit = in_ptp && cf_do && rp == `EFR_PTP_CF + 11'd7;
    wire rsv_hit = in_ptp && rsv_do && rp >= `EFR_PTP_RSV &&
        rp < `EFR_PTP_RSV + 11'd4;
    wire tod_hit = in_ptp && tod_do && rp >= `EFR_PTP_TOD &&
        rp < `EFR_PTP_TOD + `EFR_TOD_LEN;
    wire [63:0] cf_old;
    wire [63:0] cf_new = cf_old + cf_add;
    wire [15:0] cf_lo = cf_new[15:0];
    // [RULE12] [RULE13] rx stamp low word or zero
    wire [31:0] rsv_w = rx_q[31:0] << {rp[1:0], 3'b000};
    wire [7:0] rsv_b = rsv_set ? rsv_w[31:24] : 8'h00;
    // [RULE11] seconds then nanoseconds
    wire [3:0] tk = 4'(rp - `EFR_PTP_TOD);
    wire [79:0] tod_w = {tod_q, txns_q[31:0]} << {tk, 3'b000};
    wire [7:0] tod_b = tod_w[79:72];

    // [RULE1] byte entering the delay line
    wire [7:0] ent =
        cf_hit ? cf_new[7:0] :
        csum_hit ? hc_n[7:0] :
        tos_hit ? {new_dscp, src_data[1:0]} :
        tc0_hit ? {src_data[7:4], new_dscp[5:2]} :
        tc1_hit ? {new_dscp[1:0], src_data[5:0]} :
        rsv_hit ? rsv_b :
        tod_hit ? tod_b : src_data;

    // the 8-deep line holds the first seven correction field bytes
    // when the last one arrives, so the carry can run back into them
    logic [7:0] pt [8];
    assign cf_old[7:0] = src_data;
    for (genvar k = 0; k < 8; k++) begin : g_line
        if (k < 7) begin : g_cf
            assign cf_old[8*k+15 -: 8] = sh_q[k];
        end
        // [RULE9] carry-resolved correction bytes
        assign pt[k] =
            (cf_hit && k < 7) ? cf_new[8*k+15 -: 8] :
            (csum_hit && k == 0) ? hc_n[15:8] : sh_q[k];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vld_q <= 8'h0;
            for (int k = 0; k < 8; k++) begin
                sh_q[k] <= 8'h0;
            end
        end else if (go) begin
            vld_q <= {vld_q[6:0], enter};
            sh_q[0] <= enter ? ent : 8'h00;
            for (int k = 1; k < 8; k++) begin
                sh_q[k] <= pt[k-1];
            end
        end
    end

    wire any_edit = cf_hit || csum_hit || tos_hit || tc0_hit ||
        tc1_hit || rsv_hit || tod_hit;

    // ========================================================
    // exit side: fcs regeneration and output register
    logic [10:0] len_q;
    logic len_ok_q;
    logic [10:0] xi_q;
    logic [31:0] crc_q;

    function automatic [31:0] crc_byte(input [31:0] c, input [7:0] d);
        logic [31:0] x;
        x = c ^ {24'h0, d};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? (x >> 1) ^ `EFR_CRC_POLY : x >> 1;
        end
        crc_byte = x;
    endfunction

    // [RULE7] [RULE8] fcs policy per frame origin
    wire fcs_upd = cpu_q ? cfg_q[`EFR_CFG_CPU_EN] :
        fmode == efr_pkg::fm_always ||
        (fmode == efr_pkg::fm_cond && mod_q);
    wire is_fcs = len_ok_q && (xi_q + 11'd4 >= len_q);
    wire [1:0] fk = 2'(xi_q + 11'd4 - len_q);
    wire [31:0] fcs_w = ~crc_q >> {fk, 3'b000};
    wire [7:0] fcs_b = fcs_w[7:0];
    wire exit = go && vld_q[7];
    wire last = len_ok_q && xi_q == len_q - 11'd1;
    assign done = exit && last;

    always_ff @(posedge clk) begin
        if (!rst_n || done) begin
            len_q <= 11'h0;
            len_ok_q <= 1'b0;
            xi_q <= 11'h0;
            crc_q <= `EFR_CRC_INIT;
            mod_q <= 1'b0;
        end else begin
            if (enter && src_eof) begin
                len_q <= pos_q + 11'd1;
                len_ok_q <= 1'b1;
            end
            if (exit) begin
                xi_q <= xi_q + 11'd1;
            end
            // [RULE22] crc over bytes after every edit
            if (exit && !is_fcs) begin
                crc_q <= crc_byte(crc_q, sh_q[7]);
            end
            if (any_edit || (exit && tag_q)) begin
                mod_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_valid_q <= 1'b0;
            out_data <= 8'h0;
            out_sof <= 1'b0;
            out_eof <= 1'b0;
        end else if (go) begin
            out_valid_q <= vld_q[7];
            out_data <= (is_fcs && fcs_upd) ? fcs_b : sh_q[7];
            out_sof <= vld_q[7] && xi_q == 11'h0;
            out_eof <= vld_q[7] && last;
        end else if (out_ready) begin
            out_valid_q <= 1'b0;
        end
    end

    // ========================================================
    // flow control
    wire skid_v_d = skid_v_q ? !go : (take && !go);
    wire eof_d = eof_seen_q ? !done : (take && in_eof);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            skid_v_q <= 1'b0;
            skid_d_q <= 8'h0;
            skid_s_q <= 1'b0;
            skid_e_q <= 1'b0;
            drain_q <= 1'b0;
            eof_seen_q <= 1'b0;
            in_ready_q <= 1'b0;
            frames_q <= 16'h0;
        end else begin
            skid_v_q <= skid_v_d;
            if (take && !go) begin
                skid_d_q <= in_data;
                skid_s_q <= in_sof;
                skid_e_q <= in_eof;
            end
            if (done) begin
                drain_q <= 1'b0;
            end else if (enter && src_eof) begin
                drain_q <= 1'b1;
            end
            eof_seen_q <= eof_d;
            in_ready_q <= !skid_v_d && !eof_d;
            if (done) begin
                frames_q <= frames_q + 16'd1;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign in_ready = in_ready_q;
    assign out_valid = out_valid_q;

    // ========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_keep;
        mode == efr_pkg::rm_keep |-> !(tos_hit || tc0_hit || tc1_hit);
    endproperty
    a_keep: assert property (p_keep) // [RULE3]
        else $error("remark active in keep mode");

    property p_direct;
        tos_hit && mode == efr_pkg::rm_direct |=>
            sh_q[0][7:2] == $past(dscp_q);
    endproperty
    a_direct: assert property (p_direct) // [RULE2]
        else $error("direct mode wrote wrong dscp");

    property p_color;
        dscp_do && mode == efr_pkg::rm_color && dp_q |->
            new_dscp == tbl_y[dscp_q];
    endproperty
    a_color: assert property (p_color) // [RULE4]
        else $error("yellow frame not using yellow table");

    property p_ptp_off;
        ptp_do |-> !(tos_hit || tc0_hit || tc1_hit || csum_hit);
    endproperty
    a_ptp_off: assert property (p_ptp_off) // [RULE6]
        else $error("remark during ptp stamping");

    property p_csum;
        csum_hit |-> v4_q && !v6_q;
    endproperty
    a_csum: assert property (p_csum) // [RULE5]
        else $error("checksum edit outside ipv4");

    property p_cf;
        cf_hit |=> {sh_q[1], sh_q[0]} == $past(cf_lo);
    endproperty
    a_cf: assert property (p_cf) // [RULE9]
        else $error("correction field not updated");

    property p_never;
        exit && is_fcs && !cpu_q && fmode == efr_pkg::fm_never |=>
            out_data == $past(sh_q[7]);
    endproperty
    a_never: assert property (p_never) // [RULE7]
        else $error("fcs rewritten in never mode");

    property p_cpu;
        cpu_q |-> fcs_upd == cfg_q[`EFR_CFG_CPU_EN];
    endproperty
    a_cpu: assert property (p_cpu) // [RULE8]
        else $error("injected frame fcs policy wrong");

    property p_bp;
        both |-> !(cf_do || rsv_do || tod_do);
    endproperty
    a_bp: assert property (p_bp) // [RULE21]
        else $error("ptp edit with both backplanes");

    property p_clr;
        rsv_hit && rsv_clr |=> sh_q[0] == 8'h00;
    endproperty
    a_clr: assert property (p_clr) // [RULE13]
        else $error("reserved byte not cleared");

    property p_fcs;
        exit && is_fcs && fcs_upd |=> out_data == $past(fcs_b);
    endproperty
    a_fcs: assert property (p_fcs) // [RULE22]
        else $error("fcs byte not regenerated");

    c_cf: cover property (cf_hit);
    c_dscp: cover property (tos_hit);
    c_tod: cover property (tod_hit);
    c_fcs: cover property (exit && is_fcs && fcs_upd);

endmodule
`default_nettype wire

// ### dv/mac_sink.sv
// egress mac stand-in: collects rewritten bytes, may stall
// assumes one frame in flight; bench reads rx by path
`timescale 1ns/100ps
`default_nettype none

module mac_sink (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_sof,
    input wire logic out_eof,
    output logic out_ready,
    output logic [7:0] frames
);
    logic [7:0] rx [0:127];
    int n;
    logic ph_q;

    // ============================================================
    // capture
    // every other cycle stalled when slow, so output hold is exercised
    assign out_ready = rst_n & (!slow | ph_q);
    always_ff @(posedge clk) begin
        ph_q <= !ph_q & rst_n;
        if (!rst_n) begin
            frames <= 8'h00;
            n <= 0;
        end else if (out_valid & out_ready) begin
            rx[out_sof ? 0 : n] <= out_data;
            n <= out_sof ? 1 : n + 1;
            if (out_eof)
                frames <= frames + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench of the egress frame rewriter
// assumes mac_sink downstream; bench plays analyzer and cpu
`timescale 1ns/100ps
`default_nettype none
`include "efr_map.svh"

module testbench;
    logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, in_valid;
    logic in_ready, in_sof, in_eof, drop_level, addsub_flag, slow;
    logic egress_delay_flag, ingress_backplane, cpu_injected, tag_pushed;
    logic out_valid, out_ready, out_sof, out_eof;
    logic [11:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdat;
    logic [7:0] in_data, out_data, frames;
    logic [5:0] cls_dscp;
    logic [2:0] rewriter_operation_code;
    logic [47:0] receive_time_stamp, tod_seconds, tx_time_ns;
    logic [7:0] frm [0:63];
    int n_mismatch = 0;
    int comparisons = 0;

    egress_frame_rewriter u_dut (.clk, .rst_n, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .in_valid, .in_ready, .in_data, .in_sof, .in_eof, .cls_dscp,
        .drop_level, .rewriter_operation_code, .addsub_flag,
        .egress_delay_flag, .receive_time_stamp, .ingress_backplane,
        .cpu_injected, .tag_pushed, .tod_seconds, .tx_time_ns,
        .out_valid, .out_ready, .out_data, .out_sof, .out_eof);
    mac_sink u_mac (.clk, .rst_n, .slow, .out_valid, .out_data, .out_sof,
        .out_eof, .out_ready, .frames);

    // ============================================================
    // helpers
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // classic cycle: hold until ack is seen at a rising edge
    task automatic wb(logic w, logic [11:0] a, logic [31:0] d);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do @(posedge clk);
        while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk);
    endtask

    task automatic send();
        logic [7:0] f;
        f = frames;
        for (int i = 0; i < 64; i++) begin
            in_valid <= 1'b1;
            in_data <= frm[i];
            in_sof <= (i == 0);
            in_eof <= (i == 63);
            do @(posedge clk);
            while (in_ready !== 1'b1);
        end
        in_valid <= 1'b0;
        while (frames == f)
            @(posedge clk);
    endtask

    function automatic logic [31:0] crc(int n);
        logic [31:0] c;
        c = `EFR_CRC_INIT;
        for (int i = 0; i < n; i++) begin
            c = c ^ u_mac.rx[i];
            repeat (8) c = c[0] ? (c >> 1) ^ `EFR_CRC_POLY : c >> 1;
        end
        return ~c;
    endfunction

    // ============================================================
    // scenarios
    task automatic s_regs();
        wb(1'b0, `EFR_CFG_OFS, 0);
        chk("cfg rst", rdat, 0);
        wb(1'b1, `EFR_DLY_OFS, 32'h1234_5678);
        wb(1'b0, `EFR_DLY_OFS, 0);
        chk("dly", rdat, 32'h1234_5678);
        wb(1'b1, 12'h0f0, 32'hffff_ffff);
        wb(1'b0, 12'h0f0, 0);
        chk("unmapped", rdat, 0);
    endtask

    task automatic s_remark();
        logic [7:0] tos [4] = '{8'h01, 8'h15, 8'h45, 8'ha9};
        logic [15:0] sum [4] = '{16'hbafe, 16'hbaea, 16'hbaba, 16'hba56};
        wb(1'b1, 12'h114, 32'h11);
        wb(1'b1, 12'h214, 32'h2a);
        {frm[12], frm[13], frm[14], frm[15]} = 32'h0800_4501;
        {frm[24], frm[25], frm[63]} = 24'hbafe_5a;
        cls_dscp <= 6'h05;
        drop_level <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            wb(1'b1, `EFR_CFG_OFS, m);
            send();
            chk("dscp", u_mac.rx[15], tos[m]);
            chk("csum", {u_mac.rx[24], u_mac.rx[25]}, sum[m]);
            chk("fcs kept", u_mac.rx[63], 8'h5a);
        end
    endtask

    task automatic s_ptp();
        logic [23:0] ecf [4] = '{24'h00c800, 0, 24'hff9c00, 24'h012c00};
        logic [31:0] ersv [4] = '{32'hffff_ffff, 32'h64, 32'hffff_ffff, 0};
        frm = '{default: 8'h00};
        {frm[12], frm[13]} = `EFR_ET_PTP;
        {frm[30], frm[31], frm[32], frm[33]} = 32'hffff_ffff;
        slow <= 1'b1;
        receive_time_stamp <= 48'd100;
        tx_time_ns <= 48'd300;
        rewriter_operation_code <= efr_pkg::op_one;
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, `EFR_CFG_OFS, (k == 1 || k == 2) ? 32'h24 :
                (k == 3) ? 32'h10 : 32'h04);
            cpu_injected <= (k == 3);
            addsub_flag <= (k >= 2);
            ingress_backplane <= (k == 3);
            send();
            chk("cf", {u_mac.rx[26], u_mac.rx[27], u_mac.rx[28]},
                ecf[k]);
            chk("rsv", {u_mac.rx[30], u_mac.rx[31], u_mac.rx[32],
                u_mac.rx[33]}, ersv[k]);
            chk("fcs", {u_mac.rx[63], u_mac.rx[62], u_mac.rx[61],
                u_mac.rx[60]}, crc(60));
        end
    endtask

    // ============================================================
    // run
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, in_valid, in_sof, in_eof} = '0;
        {drop_level, addsub_flag, egress_delay_flag, slow} = '0;
        {ingress_backplane, cpu_injected, tag_pushed, rst_n} = '0;
        {wb_adr_i, wb_dat_i, in_data, cls_dscp} = '0;
        {receive_time_stamp, tod_seconds, tx_time_ns} = '0;
        rewriter_operation_code = efr_pkg::op_none;
        wb_sel_i = 4'hf;
        frm = '{default: 8'h00};
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        s_regs();
        s_remark();
        s_ptp();
        report_and_stop();
    end
endmodule
`default_nettype wire
